// File: hw/disconnect_regs.vh
// Register offsets, field positions, reset values and timing constants
// of the disconnect control block.
// Assumes a 32-bit APB with byte addresses and one aligned word per register.
`ifndef DISCONNECT_REGS_VH
`define DISCONNECT_REGS_VH

// =====================================================================
// Register offsets
`define OFF_MODE        8'h00
`define OFF_STATUS      8'h04
`define OFF_CMD         8'h08
`define OFF_CFG         8'h0C
`define OFF_EVT1        8'h10
`define OFF_EVT2        8'h14
`define OFF_CNT_MANUAL  8'h18
`define OFF_CNT_REMOTE  8'h1C
`define OFF_CNT_LOCAL   8'h20

// =====================================================================
// Field positions
`define ST_OUT_BIT      0
`define ST_CTRL_LSB     2
`define ST_LED_BIT      4
`define CMD_RDISC_BIT   0
`define CMD_RRECON_BIT  1
`define CFG_SWTYPE_MSB  2
`define CFG_EXTKEY_BIT  8
`define EVT_ID_MSB      1
`define EVT_ENABLE_BIT  4
`define EVT_REMOTE_BIT  5
`define EVT_NOAUTO_BIT  6
`define EVT_CDLY_LSB    8
`define EVT_DDLY_LSB    16

// =====================================================================
// Reset values and the highest mode
`define MODE_RESET      3'h1
`define SWTYPE_RESET    3'h1
`define MODE_MAX        3'h6

// =====================================================================
// Control states
`define CS_DISCONNECTED 2'h0
`define CS_CONNECTED    2'h1
`define CS_READY        2'h2

// =====================================================================
// Event selector codes
`define EVID_NONE       2'h0
`define EVID_NEUTRAL    2'h1
`define EVID_PHASE      2'h2

// =====================================================================
// Transition kinds for the mode permission check
`define K_RDISC         3'h0
`define K_RRECON        3'h1
`define K_MDISC         3'h2
`define K_MRECON        3'h3
`define K_LDISC         3'h4
`define K_LRECON        3'h5

// =====================================================================
// Hold times in seconds and the default clock rate in Hz
`define T_RECON_HOLD_S  5
`define T_DISC_HOLD_S   10
`define CLK_HZ_DEFAULT  25000000

`endif

// File: hw/event_disconnect.v
// One event-based disconnection instance with its own delays.
// Assumes a one-cycle seconds tick and a level that marks the event.
`timescale 1ns/1ps
`default_nettype none

module event_disconnect
(
  input  wire       i_clk,
  input  wire       i_rst,
  input  wire       i_tick,
  input  wire       i_cond,
  input  wire       i_enable,
  input  wire       i_conn_disabled,
  input  wire [7:0] i_conn_delay,
  input  wire [7:0] i_disc_delay,
  output reg        o_disc_req,
  output reg        o_reconn_req
);

  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_WDISC = 2'h1;
  localparam [1:0] S_TRIP = 2'h2;
  localparam [1:0] S_WCONN = 2'h3;

  reg [1:0] state_ff;
  reg [7:0] sec_ff;
  reg [1:0] nxt_state;
  reg [7:0] nxt_sec;
  reg       nxt_disc;
  reg       nxt_reconn;

  // A zero delay is treated as the least delay of one second.
  function [7:0] min1;
    input [7:0] d;
    begin
      min1 = (d == 8'h00) ? 8'h01 : d;
    end
  endfunction

  always @*
  begin
    nxt_state = state_ff;
    nxt_sec = sec_ff;
    nxt_disc = 1'b0;
    nxt_reconn = 1'b0;
    case (state_ff)
      S_IDLE:
      begin
        if (i_enable && i_cond)
        begin
          nxt_state = S_WDISC;
          nxt_sec = min1(i_disc_delay);
        end
      end
      S_WDISC:
      begin
        if (!i_cond || !i_enable)
          nxt_state = S_IDLE;
        else if (i_tick)
        begin
          if (sec_ff == 8'h01)
          begin
            nxt_disc = 1'b1;
            nxt_state = S_TRIP;
          end
          nxt_sec = sec_ff - 8'h01;
        end
      end
      S_TRIP:
      begin
        if (!i_cond)
        begin
          nxt_state = i_conn_disabled ? S_IDLE : S_WCONN;
          nxt_sec = min1(i_conn_delay);
        end
      end
      S_WCONN:
      begin
        if (i_cond)
          nxt_state = S_TRIP;
        else if (i_tick)
        begin
          if (sec_ff == 8'h01)
          begin
            nxt_reconn = 1'b1;
            nxt_state = S_IDLE;
          end
          nxt_sec = sec_ff - 8'h01;
        end
      end
      default:
        nxt_state = S_IDLE;
    endcase
  end

  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_ff <= S_IDLE;
      sec_ff <= 8'h00;
      o_disc_req <= 1'b0;
      o_reconn_req <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      sec_ff <= nxt_sec;
      o_disc_req <= nxt_disc;
      o_reconn_req <= nxt_reconn;
    end
  end

endmodule // event_disconnect

`default_nettype wire

// File: hw/disconnect_control_fsm.v
// Disconnect control: control state machine, physical output, button,
// disconnection counters, two event-based instances and an APB slave.
// Assumes all inputs are synchronous to I_REF_CLK; local requests are pulses.
//
// How it works
// - Output reads 1 connected, 0 open.
// - Control state 0 disc, 1 conn, 2 ready.
// - Mode 0..6 writable; states read-only.
// - Mode 0 forces connected unless switch type none, ignores requests.
// - Ready state: hold 5 s, release reconnects.
// - Extended key reconnects on press.
// - Manual disconnect: modes 1,2,5, 10 s hold.
// - LED blinks after manual disconnect, off after manual reconnect.
// - Separate manual, remote, local disconnection counters.
// - Remote disconnect and reconnect commands.
// - Two event instances with own settings.
// - Event selector: none, neutral, phase sequence.
// - B0 enables event disconnection.
// - B1 picks remote or local transitions.
// - B2 blocks automatic reconnection.
// - Connection delay 1-255 s after clear.
// - Disconnection delay 1-255 s after start.
// - Remote disconnect from 1 or 2 to 0.
// - Remote reconnect to 1 or 2 per mode.
// - Manual/local: 1 to 2, 2 to 1.
// - Switch type none freezes all transitions.
`timescale 1ns/1ps
`default_nettype none
`include "disconnect_regs.vh"

module disconnect_control_fsm
#(
  parameter CLK_HZ = `CLK_HZ_DEFAULT,
  parameter CNT_W  = 32
)
(
  input  wire        I_REF_CLK,
  input  wire        I_RESET,
  input  wire        I_PSEL,
  input  wire        I_PENABLE,
  input  wire        I_PWRITE,
  input  wire [7:0]  I_PADDR,
  input  wire [31:0] I_PWDATA,
  output reg  [31:0] O_PRDATA,
  output wire        O_PREADY,
  output reg         O_PSLVERR,
  input  wire        I_BUTTON,
  input  wire        I_LOCAL_DISC,
  input  wire        I_LOCAL_RECONN,
  input  wire        I_NEUTRAL_MISSING,
  input  wire        I_WRONG_PHASE,
  output wire        O_OUTPUT_STATE,
  output wire [1:0]  O_CONTROL_STATE,
  output wire        O_LED_BLINK,
  output wire        O_RECONNECT_PROMPT,
  output wire        O_CONFIRM_PROMPT,
  output wire        O_DISCONNECT_PROMPT
);

  // =====================================================================
  // Timing derived from the clock rate
  localparam [31:0] SEC_LAST = CLK_HZ - 1;
  localparam [31:0] RECON_HOLD_CYC = `T_RECON_HOLD_S * CLK_HZ;
  localparam [31:0] DISC_HOLD_CYC = `T_DISC_HOLD_S * CLK_HZ;

  // =====================================================================
  // Declarations
  reg  [1:0]       state_ff;
  reg  [1:0]       nxt_state;
  reg  [2:0]       mode_ff;
  reg  [2:0]       swtype_ff;
  reg              extkey_ff;
  reg  [31:0]      evt1_ff;
  reg  [31:0]      evt2_ff;
  reg  [CNT_W-1:0] cnt_man_ff;
  reg  [CNT_W-1:0] cnt_rem_ff;
  reg  [CNT_W-1:0] cnt_loc_ff;
  reg              led_ff;
  reg  [31:0]      presc_ff;
  reg              tick_ff;
  reg  [31:0]      hold_ff;
  reg              btn_ff;
  reg              cmd_rdisc_ff;
  reg              cmd_rrecon_ff;
  reg  [1:0]       disc_src;
  reg              man_recon_ok;
  reg  [31:0]      rdata;
  reg              rd_err;
  wire             setup;
  wire             wr_acc;
  wire             btn_press;
  wire             btn_release;
  wire             held_recon;
  wire             held_disc;
  wire             ev1_disc;
  wire             ev1_recon;
  wire             ev2_disc;
  wire             ev2_recon;
  wire             req_rdisc;
  wire             req_rrecon;
  wire             req_ldisc;
  wire             req_lrecon;
  wire             req_mdisc;
  wire             req_mrecon;

  // =====================================================================
  // Functions
  // Permission of a transition kind in a given control mode.
  function allowed;
    input [2:0] m;
    input [2:0] k;
    begin
      case (k)
        `K_RDISC:  allowed = (m != 3'h0) && (m <= `MODE_MAX);
        `K_RRECON: allowed = (m != 3'h0) && (m <= `MODE_MAX);
        `K_MDISC:  allowed = (m == 3'h1) || (m == 3'h2) || (m == 3'h5);
        `K_MRECON: allowed = (m != 3'h0) && (m <= `MODE_MAX);
        `K_LDISC:  allowed = (m != 3'h0) && (m <= `MODE_MAX);
        `K_LRECON: allowed = (m == 3'h5) || (m == 3'h6);
        default:   allowed = 1'b0;
      endcase
    end
  endfunction

  // Level of the condition that an event selector picks.
  function evt_active;
    input [1:0] id;
    input       neutral;
    input       phase;
    begin
      case (id)
        `EVID_NEUTRAL: evt_active = neutral;
        `EVID_PHASE:   evt_active = phase;
        default:       evt_active = 1'b0;
      endcase
    end
  endfunction

  // =====================================================================
  // Seconds timebase
  always @(posedge I_REF_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      presc_ff <= 32'h0000_0000;
      tick_ff <= 1'b0;
    end
    else
    begin
      tick_ff <= (presc_ff == SEC_LAST);
      if (presc_ff == SEC_LAST)
        presc_ff <= 32'h0000_0000;
      else
        presc_ff <= presc_ff + 32'h0000_0001;
    end
  end

  // =====================================================================
  // Push button hold timing
  assign btn_press = I_BUTTON && !btn_ff;
  assign btn_release = !I_BUTTON && btn_ff;
  assign held_recon = (hold_ff >= RECON_HOLD_CYC);
  assign held_disc = (hold_ff >= DISC_HOLD_CYC);

  always @(posedge I_REF_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      btn_ff <= 1'b0;
      hold_ff <= 32'h0000_0000;
    end
    else
    begin
      btn_ff <= I_BUTTON;
      if (!I_BUTTON)
        hold_ff <= 32'h0000_0000;
      else if (!held_disc)
        hold_ff <= hold_ff + 32'h0000_0001;
    end
  end

  assign O_RECONNECT_PROMPT = (state_ff == `CS_READY);
  assign O_CONFIRM_PROMPT = (state_ff == `CS_READY) && held_recon && !extkey_ff;
  assign O_DISCONNECT_PROMPT = (state_ff == `CS_CONNECTED) && held_disc &&
                               allowed(mode_ff, `K_MDISC);

  assign req_mrecon = extkey_ff ? btn_press : (btn_release && held_recon);
  assign req_mdisc = btn_release && held_disc;

  // =====================================================================
  // Event-based instances
  // Two independent event instances.
  event_disconnect u_evt1
  (
    .i_clk           (I_REF_CLK),
    .i_rst           (I_RESET),
    .i_tick          (tick_ff),
    .i_cond          (evt_active(evt1_ff[`EVT_ID_MSB:0], I_NEUTRAL_MISSING,
                                 I_WRONG_PHASE)),
    .i_enable        (evt1_ff[`EVT_ENABLE_BIT]),
    .i_conn_disabled (evt1_ff[`EVT_NOAUTO_BIT]),
    .i_conn_delay    (evt1_ff[`EVT_CDLY_LSB+7:`EVT_CDLY_LSB]),
    .i_disc_delay    (evt1_ff[`EVT_DDLY_LSB+7:`EVT_DDLY_LSB]),
    .o_disc_req      (ev1_disc),
    .o_reconn_req    (ev1_recon)
  );

  event_disconnect u_evt2
  (
    .i_clk           (I_REF_CLK),
    .i_rst           (I_RESET),
    .i_tick          (tick_ff),
    .i_cond          (evt_active(evt2_ff[`EVT_ID_MSB:0], I_NEUTRAL_MISSING,
                                 I_WRONG_PHASE)),
    .i_enable        (evt2_ff[`EVT_ENABLE_BIT]),
    .i_conn_disabled (evt2_ff[`EVT_NOAUTO_BIT]),
    .i_conn_delay    (evt2_ff[`EVT_CDLY_LSB+7:`EVT_CDLY_LSB]),
    .i_disc_delay    (evt2_ff[`EVT_DDLY_LSB+7:`EVT_DDLY_LSB]),
    .o_disc_req      (ev2_disc),
    .o_reconn_req    (ev2_recon)
  );

  // Route event requests as remote or local.
  assign req_rdisc = cmd_rdisc_ff || (ev1_disc && evt1_ff[`EVT_REMOTE_BIT]) ||
                     (ev2_disc && evt2_ff[`EVT_REMOTE_BIT]);
  assign req_rrecon = cmd_rrecon_ff || (ev1_recon && evt1_ff[`EVT_REMOTE_BIT]) ||
                      (ev2_recon && evt2_ff[`EVT_REMOTE_BIT]);
  assign req_ldisc = I_LOCAL_DISC || (ev1_disc && !evt1_ff[`EVT_REMOTE_BIT]) ||
                     (ev2_disc && !evt2_ff[`EVT_REMOTE_BIT]);
  assign req_lrecon = I_LOCAL_RECONN || (ev1_recon && !evt1_ff[`EVT_REMOTE_BIT]) ||
                      (ev2_recon && !evt2_ff[`EVT_REMOTE_BIT]);

  // =====================================================================
  // Control state machine
  // In the ready state a remote disconnect request wins over reconnect requests of the same cycle.
  always @*
  begin
    nxt_state = state_ff;
    disc_src = 2'h0;
    man_recon_ok = 1'b0;
    if (swtype_ff == 3'h0)
      nxt_state = state_ff;
    else if (mode_ff == 3'h0)
      nxt_state = `CS_CONNECTED;
    else
    begin
      case (state_ff)
        `CS_DISCONNECTED:
        begin
          // Direct in modes 2 and 4.
          if (req_rrecon && allowed(mode_ff, `K_RRECON))
            nxt_state = ((mode_ff == 3'h2) || (mode_ff == 3'h4)) ?
                        `CS_CONNECTED : `CS_READY;
        end
        `CS_CONNECTED:
        begin
          if (req_rdisc && allowed(mode_ff, `K_RDISC))
          begin
            nxt_state = `CS_DISCONNECTED;
            disc_src = 2'h2;
          end
          else if (req_ldisc && allowed(mode_ff, `K_LDISC))
          begin
            nxt_state = `CS_READY;
            disc_src = 2'h3;
          end
          // Manual disconnect in modes 1, 2, 5.
          else if (req_mdisc && allowed(mode_ff, `K_MDISC))
          begin
            nxt_state = `CS_READY;
            disc_src = 2'h1;
          end
        end
        `CS_READY:
        begin
          if (req_rdisc && allowed(mode_ff, `K_RDISC))
          begin
            nxt_state = `CS_DISCONNECTED;
            disc_src = 2'h2;
          end
          // Local reconnect in modes 5, 6.
          else if (req_lrecon && allowed(mode_ff, `K_LRECON))
            nxt_state = `CS_CONNECTED;
          else if (req_mrecon && allowed(mode_ff, `K_MRECON))
          begin
            nxt_state = `CS_CONNECTED;
            man_recon_ok = 1'b1;
          end
        end
        default:
          nxt_state = `CS_CONNECTED;
      endcase
    end
  end

  always @(posedge I_REF_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      state_ff <= `CS_CONNECTED;
      led_ff <= 1'b0;
      cnt_man_ff <= {CNT_W{1'b0}};
      cnt_rem_ff <= {CNT_W{1'b0}};
      cnt_loc_ff <= {CNT_W{1'b0}};
    end
    else
    begin
      state_ff <= nxt_state;
      if (disc_src == 2'h1)
        led_ff <= 1'b1;
      else if (man_recon_ok)
        led_ff <= 1'b0;
      if (disc_src == 2'h1)
        cnt_man_ff <= cnt_man_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      if (disc_src == 2'h2)
        cnt_rem_ff <= cnt_rem_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      if (disc_src == 2'h3)
        cnt_loc_ff <= cnt_loc_ff + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  assign O_OUTPUT_STATE = (state_ff == `CS_CONNECTED);
  assign O_CONTROL_STATE = state_ff;
  assign O_LED_BLINK = led_ff;

  // =====================================================================
  // APB slave
  // Read data is captured in the setup cycle so the access needs no wait.
  assign setup = I_PSEL && !I_PENABLE;
  assign O_PREADY = I_PSEL && I_PENABLE;
  assign wr_acc = I_PSEL && I_PENABLE && I_PWRITE;

  always @*
  begin
    rdata = 32'h0000_0000;
    rd_err = 1'b0;
    case (I_PADDR)
      `OFF_MODE:       rdata[2:0] = mode_ff;
      `OFF_STATUS:
      begin
        rdata[`ST_OUT_BIT] = O_OUTPUT_STATE;
        rdata[`ST_CTRL_LSB+1:`ST_CTRL_LSB] = state_ff;
        rdata[`ST_LED_BIT] = led_ff;
      end
      `OFF_CMD:        rdata = 32'h0000_0000;
      `OFF_CFG:
      begin
        rdata[`CFG_SWTYPE_MSB:0] = swtype_ff;
        rdata[`CFG_EXTKEY_BIT] = extkey_ff;
      end
      `OFF_EVT1:       rdata = evt1_ff;
      `OFF_EVT2:       rdata = evt2_ff;
      `OFF_CNT_MANUAL: rdata[CNT_W-1:0] = cnt_man_ff;
      `OFF_CNT_REMOTE: rdata[CNT_W-1:0] = cnt_rem_ff;
      `OFF_CNT_LOCAL:  rdata[CNT_W-1:0] = cnt_loc_ff;
      default:         rd_err = 1'b1;
    endcase
  end

  always @(posedge I_REF_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      O_PRDATA <= 32'h0000_0000;
      O_PSLVERR <= 1'b0;
      mode_ff <= `MODE_RESET;
      swtype_ff <= `SWTYPE_RESET;
      extkey_ff <= 1'b0;
      evt1_ff <= 32'h0000_0000;
      evt2_ff <= 32'h0000_0000;
      cmd_rdisc_ff <= 1'b0;
      cmd_rrecon_ff <= 1'b0;
    end
    else
    begin
      if (setup)
      begin
        O_PRDATA <= I_PWRITE ? 32'h0000_0000 : rdata;
        O_PSLVERR <= rd_err;
      end
      cmd_rdisc_ff <= 1'b0;
      cmd_rrecon_ff <= 1'b0;
      if (wr_acc)
      begin
        case (I_PADDR)
          // Mode writes above 6 are ignored.
          `OFF_MODE:
          begin
            if (I_PWDATA[2:0] <= `MODE_MAX)
              mode_ff <= I_PWDATA[2:0];
          end
          `OFF_CMD:
          begin
            cmd_rdisc_ff <= I_PWDATA[`CMD_RDISC_BIT];
            cmd_rrecon_ff <= I_PWDATA[`CMD_RRECON_BIT];
          end
          `OFF_CFG:
          begin
            swtype_ff <= I_PWDATA[`CFG_SWTYPE_MSB:0];
            extkey_ff <= I_PWDATA[`CFG_EXTKEY_BIT];
          end
          `OFF_EVT1:       evt1_ff <= I_PWDATA;
          `OFF_EVT2:       evt2_ff <= I_PWDATA;
          default:         ;
        endcase
      end
    end
  end

endmodule // disconnect_control_fsm

`default_nettype wire

// File: tb/disconnect_control_fsm_asserts.sv
// Port assertions for the disconnect control block.
// Assumes one clock domain and the asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module disconnect_control_fsm_chk
(
  input wire logic        I_REF_CLK,
  input wire logic        I_RESET,
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_PWRITE,
  input wire logic [7:0]  I_PADDR,
  input wire logic [31:0] O_PRDATA,
  input wire logic        O_PREADY,
  input wire logic        O_PSLVERR,
  input wire logic        I_BUTTON,
  input wire logic        I_LOCAL_DISC,
  input wire logic        O_OUTPUT_STATE,
  input wire logic [1:0]  O_CONTROL_STATE,
  input wire logic        O_LED_BLINK,
  input wire logic        O_RECONNECT_PROMPT,
  input wire logic        O_CONFIRM_PROMPT,
  input wire logic        O_DISCONNECT_PROMPT
);
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_RESET);
  wire setup = I_PSEL && !I_PENABLE;

  // ==================================================================
  // State and output
  out_follows_a: assert property (O_OUTPUT_STATE == (O_CONTROL_STATE == 2'h1))
    else $error("output state disagrees with control state");
  state_legal_a: assert property (O_CONTROL_STATE != 2'h3)
    else $error("control state outside 0 to 2");
  ready_prompt_a: assert property (O_RECONNECT_PROMPT == (O_CONTROL_STATE == 2'h2))
    else $error("reconnect prompt wrong");
  confirm_hold_a: assert property (O_CONFIRM_PROMPT |-> O_CONTROL_STATE == 2'h2 && $past(I_BUTTON))
    else $error("confirm prompt without held button");
  disc_prompt_a: assert property ($rose(O_DISCONNECT_PROMPT) |->
    O_CONTROL_STATE == 2'h1 && $past(I_BUTTON) && $past(I_BUTTON, 8))
    else $error("disconnect prompt without long hold");
  manual_disc_a: assert property (O_DISCONNECT_PROMPT && !I_BUTTON && !I_LOCAL_DISC
    |=> O_CONTROL_STATE == 2'h2 && O_LED_BLINK)
    else $error("release after prompt did not disconnect");
  led_clear_a: assert property ($fell(O_LED_BLINK) |-> O_CONTROL_STATE == 2'h1)
    else $error("indicator cleared without reconnection");

  // ==================================================================
  // Register bus
  pready_a: assert property (O_PREADY == (I_PSEL && I_PENABLE))
    else $error("ready does not follow access phase");
  unmapped_a: assert property (setup && I_PADDR > 8'h20 |=> O_PSLVERR && O_PRDATA == 32'h0)
    else $error("unmapped address not refused");
  mapped_ok_a: assert property (setup && I_PADDR <= 8'h20 && I_PADDR[1:0] == 2'h0 |=> !O_PSLVERR)
    else $error("mapped address refused");
  cmd_zero_a: assert property (setup && !I_PWRITE && I_PADDR == 8'h08 |=> O_PRDATA == 32'h0)
    else $error("command register read not zero");

  cover property ($rose(O_LED_BLINK));
  cover property (O_CONTROL_STATE == 2'h0);
  cover property (O_PSLVERR && O_PREADY);
endmodule // disconnect_control_fsm_chk

`default_nettype wire

// File: tb/field_side.sv
// Button, local functions and grid events around the block.
// Assumes its tasks are called from the bench; it drives after rising edges.
`timescale 1ns/1ps
`default_nettype none

module field_side
(
  input  wire logic i_clk,
  output logic      o_button = 1'b0,
  output logic      o_local_disc = 1'b0,
  output logic      o_local_reconn = 1'b0,
  output logic      o_neutral_missing = 1'b0,
  output logic      o_wrong_phase = 1'b0
);
  // press and keep held for n cycles
  task automatic press(input int n);
    @(posedge i_clk);
    o_button <= 1'b1;
    repeat (n) @(posedge i_clk);
  endtask

  // Let the button go.
  task automatic rel();
    o_button <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic hold(input int n);
    press(n);
    rel();
  endtask

  // One-cycle local request.
  task automatic pulse(input logic disc);
    @(posedge i_clk);
    o_local_disc <= disc;
    o_local_reconn <= !disc;
    @(posedge i_clk);
    o_local_disc <= 1'b0;
    o_local_reconn <= 1'b0;
  endtask

  // Grid condition levels.
  task automatic events(input logic n, input logic p);
    @(posedge i_clk);
    o_neutral_missing <= n;
    o_wrong_phase <= p;
  endtask
endmodule // field_side

`default_nettype wire

// File: tb/disconnect_control_fsm_tb.sv
// Self-checking bench for the disconnect control block.
// Assumes CLK_HZ of 20, so one second lasts 20 clock cycles.
`timescale 1ns/1ps
`default_nettype none
`include "disconnect_regs.vh"

module disconnect_control_fsm_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  pa = 8'h0;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd;
  logic [31:0] q;
  logic        rdy;
  logic        slv;
  logic        e;
  logic        ost;
  logic [1:0]  ctl;
  logic        led;
  logic        rpr;
  logic        cpr;
  logic        dpr;
  wire logic   btn;
  wire logic   ld;
  wire logic   lr;
  wire logic   nm;
  wire logic   wp;
  int          err_count = 0;
  int          total_checks = 0;

  initial forever #20 clk = ~clk;

  disconnect_control_fsm #(.CLK_HZ(20)) i_dut
  (
    .I_REF_CLK(clk), .I_RESET(rst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pwd), .O_PRDATA(prd),
    .O_PREADY(rdy), .O_PSLVERR(slv), .I_BUTTON(btn), .I_LOCAL_DISC(ld),
    .I_LOCAL_RECONN(lr), .I_NEUTRAL_MISSING(nm), .I_WRONG_PHASE(wp),
    .O_OUTPUT_STATE(ost), .O_CONTROL_STATE(ctl), .O_LED_BLINK(led),
    .O_RECONNECT_PROMPT(rpr), .O_CONFIRM_PROMPT(cpr), .O_DISCONNECT_PROMPT(dpr)
  );

  field_side p
  (
    .i_clk(clk), .o_button(btn), .o_local_disc(ld), .o_local_reconn(lr),
    .o_neutral_missing(nm), .o_wrong_phase(wp)
  );

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask

  // One APB transfer; held until ready is seen at a rising edge.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (rdy !== 1'b1);
    q = prd;
    e = slv;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Remote commands settle one edge after the write, so idle a little.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    idle(3);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] x, input string n);
    xfer(1'b0, a, 32'h0);
    chk(n, q, x);
  endtask

  task automatic st(input logic [31:0] x);
    rc(`OFF_STATUS, x, "status");
    chk("pins", {27'h0, led, ctl, 1'b0, ost}, x);
  endtask

  initial
  begin
    idle(12);
    rst <= 1'b0;
    rc(`OFF_MODE, 32'h1, "mode");
    st(32'h5);
    rc(`OFF_CFG, 32'h1, "cfg");
    rc(`OFF_CNT_MANUAL, 32'h0, "cnt_manual");
    rc(`OFF_CMD, 32'h0, "cmd");
    wr(`OFF_MODE, 32'h7);
    rc(`OFF_MODE, 32'h1, "mode");
    wr(`OFF_STATUS, 32'h0);
    st(32'h5);
    rc(8'h40, 32'h0, "unmapped");
    chk("slverr", {31'h0, e}, 32'h1);
    $display("test registers done");
    p.hold(50);
    st(32'h5);
    p.press(210);
    chk("disc_prompt", {31'h0, dpr}, 32'h1);
    p.rel();
    st(32'h18);
    rc(`OFF_CNT_MANUAL, 32'h1, "cnt_manual");
    p.press(110);
    chk("prompts", {30'h0, rpr, cpr}, 32'h3);
    p.rel();
    st(32'h5);
    $display("test manual done");
    wr(`OFF_MODE, 32'h3);
    p.press(210);
    chk("disc_prompt", {31'h0, dpr}, 32'h0);
    p.rel();
    st(32'h5);
    p.pulse(1'b1);
    st(32'h8);
    rc(`OFF_CNT_LOCAL, 32'h1, "cnt_local");
    p.pulse(1'b0);
    st(32'h8);
    wr(`OFF_CMD, 32'h1);
    st(32'h0);
    wr(`OFF_CMD, 32'h2);
    st(32'h8);
    wr(`OFF_MODE, 32'h5);
    p.pulse(1'b0);
    st(32'h5);
    wr(`OFF_MODE, 32'h6);
    p.pulse(1'b1);
    st(32'h8);
    p.pulse(1'b0);
    st(32'h5);
    wr(`OFF_MODE, 32'h2);
    wr(`OFF_CMD, 32'h1);
    st(32'h0);
    wr(`OFF_CMD, 32'h2);
    st(32'h5);
    wr(`OFF_MODE, 32'h4);
    wr(`OFF_CMD, 32'h1);
    st(32'h0);
    wr(`OFF_CMD, 32'h2);
    st(32'h5);
    $display("test modes done");
    wr(`OFF_CFG, 32'h101);
    wr(`OFF_MODE, 32'h1);
    p.pulse(1'b1);
    p.hold(3);
    st(32'h5);
    wr(`OFF_CFG, 32'h1);
    wr(`OFF_CMD, 32'h1);
    wr(`OFF_MODE, 32'h0);
    st(32'h5);
    wr(`OFF_CMD, 32'h1);
    st(32'h5);
    wr(`OFF_MODE, 32'h1);
    wr(`OFF_CFG, 32'h0);
    wr(`OFF_CMD, 32'h1);
    st(32'h5);
    wr(`OFF_CFG, 32'h1);
    rc(`OFF_CNT_REMOTE, 32'h4, "cnt_remote");
    $display("test options done");
    wr(`OFF_MODE, 32'h5);
    wr(`OFF_EVT1, 32'h0002_0201);
    p.events(1'b1, 1'b0);
    idle(70);
    st(32'h5);
    p.events(1'b0, 1'b0);
    wr(`OFF_EVT1, 32'h0002_0211);
    p.events(1'b1, 1'b0);
    idle(10);
    st(32'h5);
    idle(60);
    st(32'h8);
    rc(`OFF_CNT_LOCAL, 32'h4, "cnt_local");
    p.events(1'b0, 1'b0);
    idle(10);
    st(32'h8);
    idle(60);
    st(32'h5);
    wr(`OFF_EVT1, 32'h0);
    wr(`OFF_EVT2, 32'h0002_0272);
    p.events(1'b0, 1'b1);
    idle(70);
    st(32'h0);
    rc(`OFF_CNT_REMOTE, 32'h5, "cnt_remote");
    p.events(1'b0, 1'b0);
    idle(80);
    st(32'h0);
    rc(`OFF_CNT_MANUAL, 32'h1, "cnt_manual");
    $display("test events done");
    conclude();
  end

  // The tests take under 3000 cycles; this margin cuts off a hang.
  initial
  begin
    #(40 * 12000);
    err_count++;
    conclude();
  end
endmodule // disconnect_control_fsm_tb

bind disconnect_control_fsm disconnect_control_fsm_chk u_chk
(
  .I_REF_CLK, .I_RESET, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR, .O_PRDATA,
  .O_PREADY, .O_PSLVERR, .I_BUTTON, .I_LOCAL_DISC, .O_OUTPUT_STATE,
  .O_CONTROL_STATE, .O_LED_BLINK, .O_RECONNECT_PROMPT, .O_CONFIRM_PROMPT,
  .O_DISCONNECT_PROMPT
);

`default_nettype wire
